// [hpamc_chk.sv]
// assertions on the ports of the mode control block
`default_nettype none
module hpamc_chk (
    // clocks and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic linkClk,
    // serial pins
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // mode outputs
    input wire hpamc_pkg::hpamc_mode_t modeOut
);
    timeunit 1ns;
    timeprecision 100ps;
    // core cycles since the device last pulled sda; saturates so it never wraps
    logic [4:0] sinceAck_r;
    logic [4:0] sinceAck_nxt;
    // count up, restart while an ack is on the wire
    always_comb begin
        sinceAck_nxt = (sinceAck_r == 5'h1F) ? 5'h1F : sinceAck_r + 5'h01;
        if (sdaOe) begin
            sinceAck_nxt = 5'h00;
        end
    end
    // register the counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sinceAck_r <= 5'h1F;
        end else begin
            sinceAck_r <= sinceAck_nxt;
        end
    end
    AST_BUCK_PUMP: assert property (@(posedge core_clk) disable iff (rst)
        modeOut.buckEn == !modeOut.softPowerDown && modeOut.chargePumpEn == !modeOut.softPowerDown)
        else $error("regulator or pump enable disagrees with power-down");
    AST_AMP_OFF_DOWN: assert property (@(posedge core_clk) disable iff (rst)
        modeOut.softPowerDown |-> modeOut.ampOn == 2'b00)
        else $error("amplifier on during power-down");
    AST_FLOAT_MUTES: assert property (@(posedge core_clk) disable iff (rst)
        (modeOut.outFloat & ~modeOut.mute) == 2'b00)
        else $error("floating channel not muted");
    AST_RESET_VALUE: assert property (@(posedge core_clk) disable iff (rst)
        $fell(rst) |-> modeOut == {1'b1, 1'b0, 1'b0, 2'b00, 2'b11, 2'b00, 5'h00})
        else $error("wrong mode after reset");
    AST_CHANGE_AFTER_ACK: assert property (@(posedge core_clk) disable iff (rst)
        $changed(modeOut) |-> sinceAck_r <= 5'h0C)
        else $error("mode changed without a recent ack");
    AST_DOWN_KEEPS_REGS: assert property (@(posedge core_clk) disable iff (rst)
        $changed(modeOut.softPowerDown) |-> $stable(modeOut.mute) && $stable(modeOut.gainStep))
        else $error("power-down altered other registers");
    AST_OE_SCL_LOW: assert property (@(posedge linkClk) disable iff (rst)
        $changed(sdaOe) |-> !sclIn)
        else $error("sda drive changed while scl high");
    AST_ACK_HOLD: assert property (@(posedge linkClk) disable iff (rst)
        $rose(sdaOe) |-> sdaOe [*5] ##0 sdaOut == 1'b0)
        else $error("ack too short or data line driven high");
endmodule : hpamc_chk

bind hpamc_top hpamc_chk hpamc_chk_i (.core_clk(core_clk), .rst(rst), .linkClk(linkClk),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .modeOut(modeOut));
`default_nettype wire

// [hpamc_consts.svh]
// register offsets, field positions, reset values and bus constants of the mode control block
`ifndef HPAMC_CONSTS_SVH
`define HPAMC_CONSTS_SVH

// register offsets on the serial bus
`define HPAMC_REG_PWR 8'h01
`define HPAMC_REG_MUTE_VOL 8'h02
`define HPAMC_REG_FLOAT 8'h03

// reset values after power-up
`define HPAMC_PWR_RESET 8'h01
`define HPAMC_MUTE_VOL_RESET 8'hC0
`define HPAMC_FLOAT_RESET 8'h00

// writable bits of each register, everything else reads as zero
`define HPAMC_PWR_WMASK 8'hC1
`define HPAMC_MUTE_VOL_WMASK 8'hFE
`define HPAMC_FLOAT_WMASK 8'h03

// field positions
`define HPAMC_SOFT_DOWN_BIT 0
`define HPAMC_LEFT_ON_BIT 7
`define HPAMC_RIGHT_ON_BIT 6
`define HPAMC_LEFT_MUTE_BIT 7
`define HPAMC_RIGHT_MUTE_BIT 6
`define HPAMC_VOL_MSB 5
`define HPAMC_VOL_LSB 1
`define HPAMC_LEFT_FLOAT_BIT 1
`define HPAMC_RIGHT_FLOAT_BIT 0

// serial bus address bytes and bit count of one byte
`define HPAMC_ADDR_WR 8'hC0
`define HPAMC_ADDR_RD 8'hC1
`define HPAMC_BYTE_BITS 4'h8

`endif

// [hpamc_host_model.sv]
// two-wire bus host that writes and reads the mode control registers
`default_nettype none
module hpamc_host_model (
    // pacing clock; pins change on its falling edge
    input wire logic clk,
    // bus pins: clock, data pull-down, resolved data wire
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: scl stands high, data left to the pull-up
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // one scl phase, 100 ns, well above four link periods
    task automatic half();
        repeat (2) @(negedge clk);
    endtask : half
    // one clock; data moves a cycle after scl falls so it never looks like start or stop
    task automatic clk_bit(input logic low, output logic smp);
        sdaLow <= low;
        half();
        scl <= 1'b1;
        half();
        smp = sda;
        scl <= 1'b0;
        @(negedge clk);
    endtask : clk_bit
    // start or repeated start
    task automatic start();
        sdaLow <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sdaLow <= 1'b1;
        half();
        scl <= 1'b0;
        @(negedge clk);
    endtask : start
    // stop, then the bus is left idle
    task automatic stop();
        sdaLow <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sdaLow <= 1'b0;
        half();
    endtask : stop
    // a byte goes MSB first, then the ack clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(~b[i], d);
        end
        clk_bit(1'b0, d);
        ack = ~d;
    endtask : send_byte
    // whole byte always sent, enables resupplied by the caller
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] off,
                             input logic [7:0] data, output logic ack);
        logic a1;
        logic a2;
        logic a3;
        start();
        send_byte(addr, a1);
        send_byte(off, a2);
        send_byte(data, a3);
        stop();
        ack = a1 & a2 & a3;
    endtask : write_reg
    // set the pointer, restart, read one byte and end it with a nack
    task automatic read_reg(input logic [7:0] off, output logic [7:0] data);
        logic a;
        start();
        send_byte(8'hC0, a);
        send_byte(off, a);
        start();
        send_byte(8'hC1, a);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, data[i]);
        end
        clk_bit(1'b0, a);
        stop();
    endtask : read_reg
endmodule : hpamc_host_model
`default_nettype wire

// [hpamc_pkg.sv]
// types shared by the mode control block
`default_nettype none
`include "hpamc_consts.svh"

package hpamc_pkg;

    // serial engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_SUB = 4'h3,
        ST_SUB_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RDATA_ACK = 4'h8
    } hpamc_state_t;

    // analog mode controls; channel index 1 is left, 0 is right
    typedef struct packed {
        logic softPowerDown;
        logic buckEn;
        logic chargePumpEn;
        logic [1:0] ampOn;
        logic [1:0] mute;
        logic [1:0] outFloat;
        logic [4:0] gainStep;
    } hpamc_mode_t;

    // one accepted register write, handed from the link to the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } hpamc_wr_t;

    // merge a written byte into a register through its writable mask
    function automatic logic [7:0] hpamc_merge(input logic [7:0] old, input logic [7:0] data,
                                              input logic [7:0] mask);
        hpamc_merge = (old & ~mask) | (data & mask);
    endfunction : hpamc_merge

endpackage : hpamc_pkg

`default_nettype wire

// [hpamc_pulse_cross.sv]
// toggle-to-pulse crossing for single events between clock domains
`default_nettype none

module hpamc_pulse_cross (
    // destination clock and reset
    input wire logic clk,
    input wire logic rst,
    // toggle from the source domain, one-cycle pulse in the destination
    input wire logic srcToggle,
    output logic pulse
);

    logic toggleSync; // toggle after two stages
    logic last_r; // toggle seen one cycle before

    // bring the toggle over before anyone looks at it
    hpamc_sync2 #(.WIDTH(1)) u_sync (
        .clk(clk),
        .rst(rst),
        .async(srcToggle),
        .synced(toggleSync)
    );

    // remember the last seen level so each flip gives exactly one pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_r <= 1'b0;
        end else begin
            last_r <= toggleSync;
        end
    end

    assign pulse = toggleSync ^ last_r;

endmodule : hpamc_pulse_cross

`default_nettype wire

// [hpamc_sync2.sv]
// two flip-flop synchroniser for levels entering a clock domain
`default_nettype none

module hpamc_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] meta_r; // first stage, read only by the second

    // two stages; only the second is visible outside
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            synced <= '0;
        end else begin
            meta_r <= async;
            synced <= meta_r;
        end
    end

endmodule : hpamc_sync2

`default_nettype wire

// [hpamc_top.sv]
// headphone amplifier mode control: serial register port and analog mode outputs
`default_nettype none
`include "hpamc_consts.svh"

module hpamc_top (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link sampling clock and serial bus pins
    input wire logic linkClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // analog mode controls
    output var hpamc_pkg::hpamc_mode_t modeOut
);

    // ---------------- link domain ----------------

    logic [1:0] pinSync; // synchronised {scl, sda}
    logic sclS; // scl after two stages
    logic sdaS; // sda after two stages
    logic sclD_r; // scl one link cycle earlier
    logic sdaD_r; // sda one link cycle earlier
    logic sclRise; // scl low to high
    logic sclFall; // scl high to low
    logic startSeen; // sda falls while scl high
    logic stopSeen; // sda rises while scl high

    hpamc_pkg::hpamc_state_t st_r, st_nxt; // serial engine state
    logic [3:0] cnt_r, cnt_nxt; // bits moved in the current byte
    logic [7:0] shift_r, shift_nxt; // byte being received or sent
    logic [7:0] ptr_r, ptr_nxt; // register pointer, auto-increments
    logic oe_r, oe_nxt; // pulling sda low
    logic wrTog_r, wrTog_nxt; // flips once per accepted write
    hpamc_pkg::hpamc_wr_t wr_r, wr_nxt; // last accepted write, held for the core
    logic [7:0] shPwr_r, shPwr_nxt; // read copy of power register
    logic [7:0] shMv_r, shMv_nxt; // read copy of mute and volume
    logic [7:0] shFl_r, shFl_nxt; // read copy of float register
    logic [7:0] rdByte; // byte at the pointer for reads
    logic sdaOut_r; // open-drain data level, always low

    // pins come from outside, so they pass two stages first
    hpamc_sync2 #(.WIDTH(2)) u_pinSync (
        .clk(linkClk),
        .rst(rst),
        .async({sclIn, sdaIn}),
        .synced(pinSync)
    );

    assign sclS = pinSync[1];
    assign sdaS = pinSync[0];

    // edge and bus condition detection works on synchronised levels only
    assign sclRise = sclS & ~sclD_r;
    assign sclFall = ~sclS & sclD_r;
    assign startSeen = sclS & sclD_r & sdaD_r & ~sdaS;
    assign stopSeen = sclS & sclD_r & ~sdaD_r & sdaS;

    // read mux; unmapped offsets and reserved bits read as zero
    always_comb begin
        case (ptr_r)
            `HPAMC_REG_PWR: rdByte = shPwr_r;
            `HPAMC_REG_MUTE_VOL: rdByte = shMv_r;
            `HPAMC_REG_FLOAT: rdByte = shFl_r;
            default: rdByte = 8'h00;
        endcase
    end

    // serial engine next state
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        oe_nxt = oe_r;
        wrTog_nxt = wrTog_r;
        wr_nxt = wr_r;
        shPwr_nxt = shPwr_r;
        shMv_nxt = shMv_r;
        shFl_nxt = shFl_r;
        if (stopSeen) begin
            // stop ends any transfer and lets go of sda
            st_nxt = hpamc_pkg::ST_IDLE;
            oe_nxt = 1'b0;
        end else if (startSeen) begin
            // start or repeated start: expect an address byte
            st_nxt = hpamc_pkg::ST_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else begin
            case (st_r)
                hpamc_pkg::ST_IDLE: begin
                    oe_nxt = 1'b0;
                end
                hpamc_pkg::ST_ADDR, hpamc_pkg::ST_SUB, hpamc_pkg::ST_WDATA: begin
                    if (sclRise) begin
                        // master's bit is stable while scl is high
                        shift_nxt = {shift_r[6:0], sdaS};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (sclFall && cnt_r == `HPAMC_BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        if (st_r == hpamc_pkg::ST_ADDR) begin
                            // only our address byte is acknowledged
                            if ({shift_r[7:1], 1'b0} == `HPAMC_ADDR_WR) begin
                                st_nxt = hpamc_pkg::ST_ADDR_ACK;
                                oe_nxt = 1'b1;
                            end else begin
                                st_nxt = hpamc_pkg::ST_IDLE;
                            end
                        end else if (st_r == hpamc_pkg::ST_SUB) begin
                            ptr_nxt = shift_r;
                            st_nxt = hpamc_pkg::ST_SUB_ACK;
                            oe_nxt = 1'b1;
                        end else begin
                            st_nxt = hpamc_pkg::ST_WDATA_ACK;
                            oe_nxt = 1'b1;
                        end
                    end
                end
                hpamc_pkg::ST_ADDR_ACK: begin
                    if (sclFall) begin
                        cnt_nxt = 4'h0;
                        if (shift_r == `HPAMC_ADDR_RD) begin
                            // read: first data bit goes out right away
                            shift_nxt = rdByte;
                            oe_nxt = ~rdByte[7];
                            ptr_nxt = ptr_r + 8'h01;
                            st_nxt = hpamc_pkg::ST_RDATA;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = hpamc_pkg::ST_SUB;
                        end
                    end
                end
                hpamc_pkg::ST_SUB_ACK: begin
                    if (sclFall) begin
                        oe_nxt = 1'b0;
                        st_nxt = hpamc_pkg::ST_WDATA;
                    end
                end
                hpamc_pkg::ST_WDATA_ACK: begin
                    // the byte is only handed on once its ack clock is over
                    if (sclFall) begin
                        oe_nxt = 1'b0;
                        wr_nxt = '{addr: ptr_r, data: shift_r};
                        wrTog_nxt = ~wrTog_r;
                        ptr_nxt = ptr_r + 8'h01;
                        st_nxt = hpamc_pkg::ST_WDATA;
                        // keep the read copy in step, only the writable bits replaced
                        case (ptr_r)
                            `HPAMC_REG_PWR: shPwr_nxt =
                                hpamc_pkg::hpamc_merge(shPwr_r, shift_r, `HPAMC_PWR_WMASK);
                            `HPAMC_REG_MUTE_VOL: shMv_nxt =
                                hpamc_pkg::hpamc_merge(shMv_r, shift_r, `HPAMC_MUTE_VOL_WMASK);
                            `HPAMC_REG_FLOAT: shFl_nxt =
                                hpamc_pkg::hpamc_merge(shFl_r, shift_r, `HPAMC_FLOAT_WMASK);
                            default: shPwr_nxt = shPwr_r;
                        endcase
                    end
                end
                hpamc_pkg::ST_RDATA: begin
                    if (sclRise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (sclFall) begin
                        if (cnt_r == `HPAMC_BYTE_BITS) begin
                            // release sda for the master's ack
                            oe_nxt = 1'b0;
                            st_nxt = hpamc_pkg::ST_RDATA_ACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt = ~shift_r[6];
                        end
                    end
                end
                hpamc_pkg::ST_RDATA_ACK: begin
                    if (sclRise && sdaS) begin
                        // no ack: master wants no more bytes
                        st_nxt = hpamc_pkg::ST_IDLE;
                    end else if (sclFall) begin
                        shift_nxt = rdByte;
                        oe_nxt = ~rdByte[7];
                        ptr_nxt = ptr_r + 8'h01;
                        cnt_nxt = 4'h0;
                        st_nxt = hpamc_pkg::ST_RDATA;
                    end
                end
                default: begin
                    st_nxt = hpamc_pkg::ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // serial engine registers; read copies start at the power-up values
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            sclD_r <= 1'b1;
            sdaD_r <= 1'b1;
            st_r <= hpamc_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            oe_r <= 1'b0;
            wrTog_r <= 1'b0;
            wr_r <= '0;
            shPwr_r <= `HPAMC_PWR_RESET;
            shMv_r <= `HPAMC_MUTE_VOL_RESET;
            shFl_r <= `HPAMC_FLOAT_RESET;
            sdaOut_r <= 1'b0;
        end else begin
            sclD_r <= sclS;
            sdaD_r <= sdaS;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            oe_r <= oe_nxt;
            wrTog_r <= wrTog_nxt;
            wr_r <= wr_nxt;
            shPwr_r <= shPwr_nxt;
            shMv_r <= shMv_nxt;
            shFl_r <= shFl_nxt;
            sdaOut_r <= 1'b0;
        end
    end

    // open drain: only ever pull low
    assign sdaOut = sdaOut_r;
    assign sdaOe = oe_r;

    // ---------------- core domain ----------------

    logic wrPulse; // one core cycle per accepted write
    logic [7:0] pwr_r, pwr_nxt; // power and channel enable register
    logic [7:0] mv_r, mv_nxt; // mute and volume register
    logic [7:0] fl_r, fl_nxt; // output float register
    hpamc_pkg::hpamc_mode_t mode_r, mode_nxt; // registered analog controls
    logic softDown; // shutdown bit
    logic [1:0] chanOn; // channel enables, 1 left, 0 right
    logic [1:0] chanMute; // mute bits
    logic [1:0] chanFloat; // float bits
    logic [1:0] ampOnC; // per channel amplifier on
    logic [1:0] muteC; // per channel mute
    logic [1:0] floatC; // per channel driver release

    // the write record stays put for many scl periods after the toggle,
    // so it is safe to take once the toggle has crossed
    hpamc_pulse_cross u_wrCross (
        .clk(core_clk),
        .rst(rst),
        .srcToggle(wrTog_r),
        .pulse(wrPulse)
    );

    // register file update; shutdown never touches stored values
    always_comb begin
        pwr_nxt = pwr_r;
        mv_nxt = mv_r;
        fl_nxt = fl_r;
        if (wrPulse) begin
            case (wr_r.addr)
                `HPAMC_REG_PWR: pwr_nxt =
                    hpamc_pkg::hpamc_merge(pwr_r, wr_r.data, `HPAMC_PWR_WMASK);
                `HPAMC_REG_MUTE_VOL: mv_nxt =
                    hpamc_pkg::hpamc_merge(mv_r, wr_r.data, `HPAMC_MUTE_VOL_WMASK);
                `HPAMC_REG_FLOAT: fl_nxt =
                    hpamc_pkg::hpamc_merge(fl_r, wr_r.data, `HPAMC_FLOAT_WMASK);
                default: pwr_nxt = pwr_r; // unmapped offsets ignored
            endcase
        end
    end

    // field extraction, channel index 1 left and 0 right
    assign softDown = pwr_r[`HPAMC_SOFT_DOWN_BIT];
    assign chanOn = {pwr_r[`HPAMC_LEFT_ON_BIT], pwr_r[`HPAMC_RIGHT_ON_BIT]};
    assign chanMute = {mv_r[`HPAMC_LEFT_MUTE_BIT], mv_r[`HPAMC_RIGHT_MUTE_BIT]};
    assign chanFloat = {fl_r[`HPAMC_LEFT_FLOAT_BIT], fl_r[`HPAMC_RIGHT_FLOAT_BIT]};

    // per-channel controls
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            // shutdown forces the amplifier off whatever its enable says
            assign ampOnC[ch] = chanOn[ch] & ~softDown;
            // float always mutes too; the mute stage only helps while powered
            assign muteC[ch] = chanMute[ch] | chanFloat[ch];
            // float is taken as written; host keeps it to legal states
            assign floatC[ch] = chanFloat[ch];
        end
    endgenerate

    // assemble the analog control word
    always_comb begin
        mode_nxt.softPowerDown = softDown;
        mode_nxt.buckEn = ~softDown;
        mode_nxt.chargePumpEn = ~softDown;
        mode_nxt.ampOn = ampOnC;
        mode_nxt.mute = muteC;
        mode_nxt.outFloat = floatC;
        // zero selects lowest gain; the unused low bit is not stored
        mode_nxt.gainStep = mv_r[`HPAMC_VOL_MSB:`HPAMC_VOL_LSB];
    end

    // core registers; power-up lands in shutdown, muted, lowest gain
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwr_r <= `HPAMC_PWR_RESET;
            mv_r <= `HPAMC_MUTE_VOL_RESET;
            fl_r <= `HPAMC_FLOAT_RESET;
            mode_r <= '{softPowerDown: 1'b1, buckEn: 1'b0, chargePumpEn: 1'b0,
                        ampOn: 2'h0, mute: 2'h3, outFloat: 2'h0, gainStep: 5'h00};
        end else begin
            pwr_r <= pwr_nxt;
            mv_r <= mv_nxt;
            fl_r <= fl_nxt;
            mode_r <= mode_nxt;
        end
    end

    assign modeOut = mode_r;

endmodule : hpamc_top

`default_nettype wire

// [tb.sv]
// self-checking bench for the mode control block
`default_nettype none
`include "hpamc_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // clocks, reset, pins
    logic core_clk = 1'b0;
    logic linkClk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic hostLow;
    logic sdaOut;
    logic sdaOe;
    hpamc_pkg::hpamc_mode_t modeOut;
    // pulled-up data wire: low if either side pulls
    wire logic sda = ~(sdaOe | hostLow);
    // shadow registers and bookkeeping
    logic [7:0] r1;
    logic [7:0] r2;
    logic [7:0] r3;
    int errors = 0;
    int nChecks = 0;
    int cycles = 0;
    logic [7:0] muteVals [4] = '{8'h80, 8'h41, 8'h00, 8'h3E};
    logic [7:0] floatVals [4] = '{8'h02, 8'h01, 8'h03, 8'h00};
    always #25 core_clk = ~core_clk;
    always #7.5 linkClk = ~linkClk;
    hpamc_top hpamc_top_i (.core_clk(core_clk), .rst(rst), .linkClk(linkClk), .sclIn(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .modeOut(modeOut));
    hpamc_host_model hpamc_host_model_i (.clk(core_clk), .scl(scl), .sdaLow(hostLow), .sda(sda));
    // expected mode outputs from the stored register bytes
    function automatic logic [15:0] expMode(input logic [7:0] a, input logic [7:0] b,
                                            input logic [7:0] c);
        expMode = {2'b00, a[0], ~a[0], ~a[0], a[7] & ~a[0], a[6] & ~a[0],
                   b[7] | c[1], b[6] | c[0], c[1:0], b[5:1]};
    endfunction : expMode
    // closing report and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // one comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // read one register and compare with its shadow
    task automatic rd(input logic [7:0] off, input logic [7:0] exp);
        logic [7:0] d;
        hpamc_host_model_i.read_reg(off, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rd
    // write, then check ack and mode outputs; reserved bits never stored
    task automatic wr(input logic [7:0] addr, input logic [7:0] off, input logic [7:0] data,
                      input logic expAck);
        logic a;
        hpamc_host_model_i.write_reg(addr, off, data, a);
        if (expAck && off == `HPAMC_REG_PWR) begin
            r1 = data & `HPAMC_PWR_WMASK;
        end
        if (expAck && off == `HPAMC_REG_MUTE_VOL) begin
            r2 = data & `HPAMC_MUTE_VOL_WMASK;
        end
        if (expAck && off == `HPAMC_REG_FLOAT) begin
            r3 = data & `HPAMC_FLOAT_WMASK;
        end
        // link sync plus core crossing settle well inside ten cycles
        repeat (10) @(negedge core_clk);
        chk({15'h0000, a}, {15'h0000, expAck});
        chk(16'(modeOut), expMode(r1, r2, r3));
    endtask : wr
    // reset pulse, then power-up values at pins and in registers
    task automatic reset_dut(input string name);
        rst <= 1'b1;
        repeat (2) @(negedge core_clk);
        rst <= 1'b0;
        repeat (4) @(negedge core_clk);
        r1 = `HPAMC_PWR_RESET;
        r2 = `HPAMC_MUTE_VOL_RESET;
        r3 = `HPAMC_FLOAT_RESET;
        chk(16'(modeOut), expMode(r1, r2, r3));
        rd(`HPAMC_REG_PWR, r1);
        rd(`HPAMC_REG_MUTE_VOL, r2);
        rd(`HPAMC_REG_FLOAT, r3);
        $display("test %s done", name);
    endtask : reset_dut
    // hang guard: the whole sequence needs about 4200 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    // main sequence
    initial begin
        reset_dut("power-up");
        wr(8'hC0, 8'h01, 8'hC0, 1'b1);
        foreach (muteVals[i]) begin
            wr(8'hC0, 8'h02, muteVals[i], 1'b1);
        end
        $display("test mute done");
        wr(8'hC0, 8'h01, 8'hC1, 1'b1);
        rd(8'h02, r2);
        rd(8'h01, r1);
        wr(8'hC0, 8'h01, 8'hC0, 1'b1);
        $display("test power-down done");
        wr(8'hC0, 8'h01, 8'h00, 1'b1);
        foreach (floatVals[i]) begin
            wr(8'hC0, 8'h03, floatVals[i], 1'b1);
        end
        $display("test float done");
        wr(8'hC2, 8'h01, 8'hC1, 1'b0);
        // both enables go up first, so the shutdown write below is a legal one
        wr(8'hC0, 8'h01, 8'hC0, 1'b1);
        wr(8'hC0, 8'h01, 8'hFF, 1'b1);
        rd(8'h01, r1);
        $display("test address and reserved done");
        reset_dut("second reset");
        stop_test();
    end
endmodule : tb
`default_nettype wire
